// ===== adcsc_top.sv
// Sequencing, digital correction, DMA request and interrupt logic of the converter.
// Assumes an analog core that accepts a sample strobe and returns a raw code per conversion.
`timescale 1ns/1ps

// Overview of operation
// - Start only after the trigger has been synchronized into the converter clock.
// - Sample the channel during the first (sample length + 1) cycles of a conversion.
// - Larger sample length field gives a longer sampling phase.
// - With correction on, subtract offset value from raw code before storing.
// - With correction on, multiply offset-corrected value by gain value.
// - Correction adds 13 converter cycles before result is available.
// - Free running pays correction latency only on first conversion.
// - Single conversion pays correction latency on every conversion.
// - DMA request rises when result is ready, falls when result is read.
// - With averaging, DMA request only after averaging completes.
// - Three interrupt sources: result ready, window monitor, overrun.
// - Flags set on their condition regardless of enable.
// - Enable-set writes of one enable, enable-clear writes of one disable.
// - Interrupt request while flag set and enabled, until cleared or reset.
// - Writing one to a flag bit clears it; zero leaves it.
// - Window mode, main enable and comparator enable writes are synchronized.
// - Free running keeps converting and sets result ready every conversion, or every fourth conversion with averaging on.
module adcsc_top #(
  parameter int DW = 12
) (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          reset_i,
  // Avalon-MM slave
  input  wire logic [5:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  // Event start trigger
  input  wire logic          evt_start_i,
  // Analog core
  input  wire logic [DW-1:0] core_data_i,
  output logic               core_sample_o,
  // System outputs
  output logic               dma_req_o,
  output logic               irq_o
);

  // ==========================================================================
  // Registers
  logic [31:0]          rdata_ff, nxt_rdata;
  logic                 ack_ff, nxt_ack;
  logic [6:0]           cfg_raw_ff, nxt_cfg_raw;
  logic [7:0]           samplen_ff, nxt_samplen;
  logic [DW-1:0]        offset_ff, nxt_offset;
  logic [DW-1:0]        gain_ff, nxt_gain;
  logic [2:0]           irq_en_ff, nxt_irq_en;
  logic [2:0]           flags_ff, nxt_flags;
  logic [DW-1:0]        result_ff, nxt_result;
  logic [DW-1:0]        win_lo_ff, nxt_win_lo;
  logic                 sw_start_ff, nxt_sw_start;
  logic [1:0]           trig_sync_ff, nxt_trig_sync;
  logic                 dma_ff, nxt_dma;
  logic                 irq_ff, nxt_irq;
  logic                 sample_ff, nxt_sample;
  adcsc_pkg::adcsc_state_e state_ff, nxt_state;
  logic [7:0]           cnt_ff, nxt_cnt;
  logic [DW-1:0]        raw_ff, nxt_raw;
  logic                 warm_ff, nxt_warm;
  logic [DW+1:0]        acc_ff, nxt_acc;
  logic [2:0]           avg_cnt_ff, nxt_avg_cnt;

  logic [6:0]           cfg_q;
  logic                 cfg_busy;
  adcsc_pkg::adcsc_cfg_s cfg;
  logic                 wr_hit, rd_hit, rd_result;
  logic                 done_evt, win_evt;
  logic [DW-1:0]        conv_val;

  // ==========================================================================
  // Configuration crossing
  adcsc_sync #(
    .WIDTH  (7),
    .STAGES (adcsc_pkg::SYNC_STAGES)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .d_i       (cfg_raw_ff),
    .q_o       (cfg_q),
    .busy_o    (cfg_busy)
  );

  // Only enable, comparator enable and window mode travel the crossing.
  always_comb begin
    cfg.enable  = cfg_q[adcsc_pkg::CTRL_ENABLE_BIT];
    cfg.corren  = cfg_raw_ff[adcsc_pkg::CTRL_CORREN_BIT];
    cfg.freerun = cfg_raw_ff[adcsc_pkg::CTRL_FREERUN_BIT];
    cfg.avg     = cfg_raw_ff[adcsc_pkg::CTRL_AVG_BIT];
    cfg.cmpen   = cfg_q[adcsc_pkg::CTRL_CMPEN_BIT];
    cfg.winmode = cfg_q[6:5];
  end

  // ==========================================================================
  // Correction arithmetic
  // Gain is a fixed point factor with unity at the top bit; the product saturates.
  function automatic logic [DW-1:0] correct(input logic [DW-1:0] raw,
                                            input logic [DW-1:0] ofs,
                                            input logic [DW-1:0] gn);
    logic [DW:0]     diff;
    logic [2*DW:0]   prod;
    diff = {1'b0, raw} - {1'b0, ofs};
    if (diff[DW]) begin
      diff = '0;
    end
    prod = diff * {1'b0, gn};
    if (|prod[2*DW:2*DW-1]) begin
      correct = '1;
    end else begin
      correct = prod[2*DW-2:DW-1];
    end
  endfunction

  // ==========================================================================
  // Bus slave
  always_comb begin
    wr_hit    = avs_write_i & ~ack_ff;
    rd_hit    = avs_read_i & ~ack_ff;
    rd_result = rd_hit && (avs_address_i == adcsc_pkg::OFS_RESULT);
    nxt_ack   = (avs_read_i | avs_write_i) & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (rd_hit) begin
      if (avs_address_i == adcsc_pkg::OFS_CTRL) begin
        nxt_rdata = {25'h0, cfg_raw_ff};
      end else if (avs_address_i == adcsc_pkg::OFS_SAMPLEN) begin
        nxt_rdata = {24'h0, samplen_ff};
      end else if (avs_address_i == adcsc_pkg::OFS_OFFSET) begin
        nxt_rdata = {20'h0, offset_ff};
      end else if (avs_address_i == adcsc_pkg::OFS_GAIN) begin
        nxt_rdata = {20'h0, gain_ff};
      end else if (avs_address_i == adcsc_pkg::OFS_WINDOW_CONTROL_REGISTER) begin
        nxt_rdata = {20'h0, win_lo_ff};
      end else if ((avs_address_i == adcsc_pkg::OFS_IRQ_SET) ||
                   (avs_address_i == adcsc_pkg::OFS_IRQ_CLR)) begin
        nxt_rdata = {29'h0, irq_en_ff};
      end else if (avs_address_i == adcsc_pkg::OFS_FLAGS) begin
        nxt_rdata = {29'h0, flags_ff};
      end else if (avs_address_i == adcsc_pkg::OFS_RESULT) begin
        nxt_rdata = {20'h0, result_ff};
      end else if (avs_address_i == adcsc_pkg::OFS_STATUS) begin
        nxt_rdata = {28'h0, cfg_busy, state_ff};
      end else begin
        nxt_rdata = adcsc_pkg::RESET_WORD;
      end
    end
  end

  always_comb begin
    nxt_cfg_raw  = cfg_raw_ff;
    nxt_samplen  = samplen_ff;
    nxt_offset   = offset_ff;
    nxt_gain     = gain_ff;
    nxt_win_lo   = win_lo_ff;
    nxt_irq_en   = irq_en_ff;
    nxt_sw_start = 1'b0;
    if (wr_hit) begin
      if (avs_address_i == adcsc_pkg::OFS_CTRL) begin
        nxt_cfg_raw[4:0] = avs_writedata_i[4:0];
      end else if (avs_address_i == adcsc_pkg::OFS_SAMPLEN) begin
        nxt_samplen = avs_writedata_i[7:0];
      end else if (avs_address_i == adcsc_pkg::OFS_OFFSET) begin
        nxt_offset = avs_writedata_i[DW-1:0];
      end else if (avs_address_i == adcsc_pkg::OFS_GAIN) begin
        nxt_gain = avs_writedata_i[DW-1:0];
      end else if (avs_address_i == adcsc_pkg::OFS_WINDOW_CONTROL_REGISTER) begin
        nxt_win_lo       = avs_writedata_i[DW-1:0];
        nxt_cfg_raw[6:5] = avs_writedata_i[17:16];
      end else if (avs_address_i == adcsc_pkg::OFS_IRQ_SET) begin
        nxt_irq_en = irq_en_ff | avs_writedata_i[2:0];
      end else if (avs_address_i == adcsc_pkg::OFS_IRQ_CLR) begin
        nxt_irq_en = irq_en_ff & ~avs_writedata_i[2:0];
      end else if (avs_address_i == adcsc_pkg::OFS_START) begin
        nxt_sw_start = avs_writedata_i[0];
      end
    end
  end

  // ==========================================================================
  // Trigger synchronization
  always_comb begin
    nxt_trig_sync = {trig_sync_ff[0], sw_start_ff | evt_start_i};
  end

  // ==========================================================================
  // Conversion sequencer
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_raw     = raw_ff;
    nxt_sample  = 1'b0;
    nxt_warm    = warm_ff;
    nxt_acc     = acc_ff;
    nxt_avg_cnt = avg_cnt_ff;
    nxt_result  = result_ff;
    done_evt    = 1'b0;
    conv_val    = cfg.corren ? correct(raw_ff, offset_ff, gain_ff) : raw_ff;
    case (state_ff)
      adcsc_pkg::ST_IDLE: begin
        nxt_warm = 1'b0;
        if (cfg.enable && trig_sync_ff[1]) begin
          nxt_state  = adcsc_pkg::ST_SAMPLE;
          nxt_cnt    = samplen_ff;
          nxt_sample = 1'b1;
        end
      end
      adcsc_pkg::ST_SAMPLE: begin
        nxt_sample = 1'b1;
        if (cnt_ff == 8'h00) begin
          nxt_state  = adcsc_pkg::ST_CONVERT;
          nxt_cnt    = 8'(adcsc_pkg::CONV_CYCLES - 1);
          nxt_sample = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      adcsc_pkg::ST_CONVERT: begin
        if (cnt_ff == 8'h00) begin
          nxt_raw = core_data_i;
          if (cfg.corren && !warm_ff) begin
            nxt_state = adcsc_pkg::ST_CORRECT;
            nxt_cnt   = 8'(adcsc_pkg::CORR_LATENCY - 1);
          end else begin
            nxt_state = adcsc_pkg::ST_STORE;
          end
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      adcsc_pkg::ST_CORRECT: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = adcsc_pkg::ST_STORE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      adcsc_pkg::ST_STORE: begin
        if (cfg.avg) begin
          nxt_acc     = acc_ff + {2'b00, conv_val};
          nxt_avg_cnt = avg_cnt_ff + 3'h1;
          if (avg_cnt_ff == 3'(adcsc_pkg::AVG_SAMPLES - 1)) begin
            nxt_result  = nxt_acc[DW+1:2];
            nxt_acc     = '0;
            nxt_avg_cnt = '0;
            done_evt    = 1'b1;
          end
        end else begin
          nxt_result = conv_val;
          done_evt   = 1'b1;
        end
        // The pipeline stays full while free running, so later results skip the wait.
        nxt_warm = cfg.freerun;
        if (cfg.enable && (cfg.freerun || (cfg.avg && !done_evt))) begin
          nxt_state  = adcsc_pkg::ST_SAMPLE;
          nxt_cnt    = samplen_ff;
          nxt_sample = 1'b1;
        end else begin
          nxt_state = adcsc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = adcsc_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Flags, DMA request and interrupt
  always_comb begin
    win_evt = done_evt && cfg.cmpen && (cfg.winmode != 2'b00) &&
              (nxt_result < win_lo_ff);
    nxt_flags = flags_ff;
    if (wr_hit && (avs_address_i == adcsc_pkg::OFS_FLAGS)) begin
      nxt_flags = flags_ff & ~avs_writedata_i[2:0];
    end
    if (done_evt) begin
      nxt_flags[adcsc_pkg::FLAG_RESULT_READY_FLAG_BIT] = 1'b1;
    end
    if (done_evt && flags_ff[adcsc_pkg::FLAG_RESULT_READY_FLAG_BIT] && dma_ff) begin
      nxt_flags[adcsc_pkg::FLAG_OVERRUN_BIT] = 1'b1;
    end
    if (win_evt) begin
      nxt_flags[adcsc_pkg::FLAG_WINDOW_MONITOR_FLAG_BIT] = 1'b1;
    end
    nxt_dma = dma_ff;
    if (rd_result) begin
      nxt_dma = 1'b0;
    end
    if (done_evt) begin
      nxt_dma = 1'b1;
    end
    nxt_irq = |(nxt_flags & nxt_irq_en);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_ff     <= adcsc_pkg::RESET_WORD;
      ack_ff       <= 1'b0;
      cfg_raw_ff   <= '0;
      samplen_ff   <= '0;
      offset_ff    <= '0;
      gain_ff      <= adcsc_pkg::GAIN_UNITY;
      win_lo_ff    <= '0;
      irq_en_ff    <= '0;
      flags_ff     <= '0;
      result_ff    <= '0;
      sw_start_ff  <= 1'b0;
      trig_sync_ff <= '0;
      dma_ff       <= 1'b0;
      irq_ff       <= 1'b0;
      sample_ff    <= 1'b0;
      state_ff     <= adcsc_pkg::ST_IDLE;
      cnt_ff       <= '0;
      raw_ff       <= '0;
      warm_ff      <= 1'b0;
      acc_ff       <= '0;
      avg_cnt_ff   <= '0;
    end else begin
      rdata_ff     <= nxt_rdata;
      ack_ff       <= nxt_ack;
      cfg_raw_ff   <= nxt_cfg_raw;
      samplen_ff   <= nxt_samplen;
      offset_ff    <= nxt_offset;
      gain_ff      <= nxt_gain;
      win_lo_ff    <= nxt_win_lo;
      irq_en_ff    <= nxt_irq_en;
      flags_ff     <= nxt_flags;
      result_ff    <= nxt_result;
      sw_start_ff  <= nxt_sw_start;
      trig_sync_ff <= nxt_trig_sync;
      dma_ff       <= nxt_dma;
      irq_ff       <= nxt_irq;
      sample_ff    <= nxt_sample;
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      raw_ff       <= nxt_raw;
      warm_ff      <= nxt_warm;
      acc_ff       <= nxt_acc;
      avg_cnt_ff   <= nxt_avg_cnt;
    end
  end

  // The first cycle of a request waits; the answer comes on the second edge.
  always_comb begin
    avs_readdata_o    = rdata_ff;
    avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
    core_sample_o     = sample_ff;
    dma_req_o         = dma_ff;
    irq_o             = irq_ff;
  end

endmodule

// ===== adcsc_pkg.sv
// Package for the converter sequencing, correction and interrupt block.
// Assumes a single 125 MHz system clock that also serves as the converter clock.
package adcsc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the Avalon-MM slave).
  localparam logic [5:0] OFS_CTRL     = 6'h00;
  localparam logic [5:0] OFS_SAMPLEN  = 6'h04;
  localparam logic [5:0] OFS_OFFSET   = 6'h08;
  localparam logic [5:0] OFS_GAIN     = 6'h0C;
  localparam logic [5:0] OFS_WINDOW_CONTROL_REGISTER  = 6'h10;
  localparam logic [5:0] OFS_IRQ_SET  = 6'h14;
  localparam logic [5:0] OFS_IRQ_CLR  = 6'h18;
  localparam logic [5:0] OFS_FLAGS    = 6'h1C;
  localparam logic [5:0] OFS_RESULT   = 6'h20;
  localparam logic [5:0] OFS_START    = 6'h24;
  localparam logic [5:0] OFS_STATUS   = 6'h28;

  // ==========================================================================
  // Field positions.
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_CORREN_BIT   = 1;
  localparam int CTRL_FREERUN_BIT  = 2;
  localparam int CTRL_AVG_BIT      = 3;
  localparam int CTRL_CMPEN_BIT    = 4;
  localparam int FLAG_RESULT_READY_FLAG_BIT   = 0;
  localparam int FLAG_OVERRUN_BIT  = 1;
  localparam int FLAG_WINDOW_MONITOR_FLAG_BIT   = 2;
  localparam int WIN_MODE_LSB      = 0;

  // ==========================================================================
  // Reset values and timing counts.
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [11:0] GAIN_UNITY   = 12'h800;
  localparam int          CORR_LATENCY = 13;
  localparam int          CONV_CYCLES  = 12;
  localparam int          AVG_SAMPLES  = 4;
  localparam int          SYNC_STAGES  = 2;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_CORRECT,
    ST_STORE
  } adcsc_state_e;

  typedef struct packed {
    logic        enable;
    logic        corren;
    logic        freerun;
    logic        avg;
    logic        cmpen;
    logic [1:0]  winmode;
  } adcsc_cfg_s;

endpackage

// ===== adcsc_sync.sv
// Write synchronizer for configuration bits entering the converter domain.
// Assumes the source is a register on the same clock; the stages model the crossing delay.
`timescale 1ns/1ps
module adcsc_sync #(
  parameter int WIDTH  = 7,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o,
  output logic                  busy_o
);

  // ==========================================================================
  // Shift stages
  logic [WIDTH-1:0] stage_ff     [STAGES];
  logic [WIDTH-1:0] nxt_stage    [STAGES];

  always_comb begin
    nxt_stage[0] = d_i;
    for (int i = 1; i < STAGES; i++) begin
      nxt_stage[i] = stage_ff[i-1];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < STAGES; i++) begin
      if (reset_i) begin
        stage_ff[i] <= '0;
      end else begin
        stage_ff[i] <= nxt_stage[i];
      end
    end
  end

  assign q_o    = stage_ff[STAGES-1];
  assign busy_o = (d_i != stage_ff[STAGES-1]);

endmodule

// ===== adcsc_core_model.sv
// Behavioural analog core that returns the bench's code for each conversion.
// Assumes the block holds core_sample_o high for the whole sampling phase.
`timescale 1ns/1ps
module adcsc_core_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Block side
  input  wire logic        core_sample_o,
  output logic      [11:0] core_data_o,
  // Bench side
  input  wire logic [11:0] code_i
);
  // ==========================================================================
  // Sample and hold
  logic samp_q_ff;
  initial begin
    samp_q_ff   = 1'b0;
    core_data_o = 12'h000;
  end
  // During sampling the line shows the previous output inverted, so an early read fails.
  always @(posedge clk_sys_i) begin
    samp_q_ff <= core_sample_o;
    if (samp_q_ff && !core_sample_o) begin
      core_data_o <= code_i;
    end else if (!samp_q_ff && core_sample_o) begin
      core_data_o <= ~core_data_o;
    end
  end
endmodule

// ===== adcsc_top_monitor.sv
// Checker for the converter block, bound to adcsc_top.
// Assumes it sees only the top ports; configuration is shadowed from bus writes.
`timescale 1ns/1ps
module adcsc_top_monitor (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          reset_i,
  // Avalon-MM slave
  input  wire logic [5:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  input  wire logic          avs_waitrequest_o,
  // Trigger, core and outputs
  input  wire logic          evt_start_i,
  input  wire logic          core_sample_o,
  input  wire logic          dma_req_o,
  input  wire logic          irq_o
);
  // ==========================================================================
  // Shadow configuration and phase counters
  logic [7:0] samplen_ff;
  logic       freerun_ff;
  logic       corren_ff;
  logic [8:0] hi_ff;
  logic [5:0] gap_ff;
  logic       wr_ok;
  logic       rd_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  assign rd_ok = avs_read_i && !avs_waitrequest_o;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      samplen_ff <= 8'h00;
      freerun_ff <= 1'b0;
      corren_ff  <= 1'b0;
      hi_ff      <= 9'h000;
      gap_ff     <= 6'h00;
    end else begin
      if (wr_ok && avs_address_i == adcsc_pkg::OFS_SAMPLEN) begin
        samplen_ff <= avs_writedata_i[7:0];
      end
      if (wr_ok && avs_address_i == adcsc_pkg::OFS_CTRL) begin
        freerun_ff <= avs_writedata_i[adcsc_pkg::CTRL_FREERUN_BIT];
        corren_ff  <= avs_writedata_i[adcsc_pkg::CTRL_CORREN_BIT];
      end
      hi_ff  <= core_sample_o ? hi_ff + 9'h001 : 9'h000;
      gap_ff <= core_sample_o ? 6'h00 : (gap_ff == 6'h3F ? gap_ff : gap_ff + 6'h01);
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  a_wait_first:
    assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
      else $error("no wait state");
  a_wait_short:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("answer late");
  a_wait_idle:
    assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("idle wait");
  a_reset_quiet:
    assert property ($fell(reset_i) |-> !dma_req_o && !irq_o && !core_sample_o)
      else $error("outputs active");
  a_start_synced:
    assert property ($rose(evt_start_i) && !freerun_ff && !core_sample_o |=> !core_sample_o)
      else $error("start not synced");
  a_sample_length:
    assert property ($fell(core_sample_o) |-> hi_ff == {1'b0, samplen_ff} + 9'h001)
      else $error("sample length");
  a_raw_latency:
    assert property ($rose(dma_req_o) && !freerun_ff && !corren_ff |-> gap_ff inside {[12:16]})
      else $error("raw latency");
  a_corr_latency:
    assert property ($rose(dma_req_o) && !freerun_ff && corren_ff |-> gap_ff inside {[25:29]})
      else $error("corrected latency");
  a_dma_cleared:
    assert property (rd_ok && avs_address_i == adcsc_pkg::OFS_RESULT && !freerun_ff
      |=> ##1 !dma_req_o)
      else $error("dma kept after read");
  a_irq_disabled:
    assert property (wr_ok && avs_address_i == adcsc_pkg::OFS_IRQ_CLR
      && avs_writedata_i[2:0] == 3'h7 |=> ##1 !irq_o)
      else $error("irq kept after disable");
endmodule
bind adcsc_top adcsc_top_monitor u_monitor (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .evt_start_i(evt_start_i), .core_sample_o(core_sample_o),
  .dma_req_o(dma_req_o), .irq_o(irq_o));

// ===== tb_adc_sequencing_correction_irq.sv
// Self-checking bench for the converter sequencing, correction and interrupt block.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_adc_sequencing_correction_irq;
  // ==========================================================================
  // Signals
  logic        clk_sys_i       = 1'b0;
  logic        reset_i         = 1'b1;
  logic [5:0]  avs_address_i   = 6'h00;
  logic        avs_read_i      = 1'b0;
  logic        avs_write_i     = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic        evt_start_i     = 1'b0;
  logic [11:0] code            = 12'h000;
  logic        samp_q          = 1'b0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [11:0] core_data;
  logic        core_sample_o;
  logic        dma_req_o;
  logic        irq_o;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  int          rises      = 0;
  logic [11:0] tc[3]      = '{12'h400, 12'hFFF, 12'h005};
  logic [11:0] to[3]      = '{12'h010, 12'h000, 12'h010};
  logic [11:0] tg[3]      = '{12'hC00, 12'hFFF, 12'h800};
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc    <= cyc + 1;
    samp_q <= core_sample_o;
    if (core_sample_o && !samp_q) rises <= rises + 1;
  end
  adcsc_top #(.DW(12)) u_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .evt_start_i(evt_start_i), .core_data_i(core_data), .core_sample_o(core_sample_o),
    .dma_req_o(dma_req_o), .irq_o(irq_o));
  adcsc_core_model u_core (
    .clk_sys_i(clk_sys_i), .core_sample_o(core_sample_o), .core_data_o(core_data),
    .code_i(code));
  // ==========================================================================
  // Helpers
  function automatic logic [11:0] corr(input logic [11:0] c, input logic [11:0] o,
                                       input logic [11:0] g);
    logic [23:0] p;
    p = (c > o) ? ((24'(c - o) * 24'(g)) >> 11) : 24'h0;
    return (p > 24'h000FFF) ? 12'hFFF : p[11:0];
  endfunction
  // An idle edge follows each request.
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_read_i      <= rd;
    avs_write_i     <= !rd;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask
  task automatic wait_dma(output int t);
    while (dma_req_o !== 1'b1) @(posedge clk_sys_i);
    t = cyc;
  endtask
  task automatic conv(input logic evt, output logic [31:0] q);
    int t;
    if (evt) begin
      evt_start_i <= 1'b1;
      @(posedge clk_sys_i);
      evt_start_i <= 1'b0;
    end else wr(adcsc_pkg::OFS_START, 32'h1);
    wait_dma(t);
    bus(1'b1, adcsc_pkg::OFS_RESULT, 32'h0, q);
    @(posedge clk_sys_i);
    `CHK(dma_req_o, 1'b0)
  endtask
  task automatic poll(input logic [31:0] m, output logic [31:0] f);
    do bus(1'b1, adcsc_pkg::OFS_FLAGS, 32'h0, f);
    while ((f & m) == 32'h0);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] q;
    bus(1'b1, adcsc_pkg::OFS_FLAGS, 32'h0, q);
    `CHK(q, 32'h0)
    bus(1'b1, adcsc_pkg::OFS_IRQ_SET, 32'h0, q);
    `CHK(q, 32'h0)
    bus(1'b1, adcsc_pkg::OFS_GAIN, 32'h0, q);
    `CHK(q[11:0], adcsc_pkg::GAIN_UNITY)
    bus(1'b1, 6'h3C, 32'h0, q);
    `CHK(q, 32'h0)
    `CHK({dma_req_o, irq_o, core_sample_o}, 3'b000)
  endtask
  task automatic t_raw();
    logic [31:0] q;
    wr(adcsc_pkg::OFS_CTRL, 32'h1);
    wr(adcsc_pkg::OFS_SAMPLEN, 32'h3);
    code <= 12'h5A5;
    conv(1'b0, q);
    `CHK(q[11:0], 12'h5A5)
    poll(32'h1, q);
    `CHK(q[2:0], 3'b001)
    `CHK(irq_o, 1'b0)
    wr(adcsc_pkg::OFS_FLAGS, 32'h0);
    bus(1'b1, adcsc_pkg::OFS_FLAGS, 32'h0, q);
    `CHK(q[0], 1'b1)
    wr(adcsc_pkg::OFS_FLAGS, 32'h1);
    bus(1'b1, adcsc_pkg::OFS_FLAGS, 32'h0, q);
    `CHK(q[0], 1'b0)
  endtask
  task automatic t_corr();
    logic [31:0] q;
    wr(adcsc_pkg::OFS_CTRL, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(adcsc_pkg::OFS_OFFSET, {20'h0, to[i]});
      wr(adcsc_pkg::OFS_GAIN, {20'h0, tg[i]});
      code <= tc[i];
      conv(i == 0, q);
      `CHK(q[11:0], corr(tc[i], to[i], tg[i]))
    end
    wr(adcsc_pkg::OFS_CTRL, 32'h1);
    wr(adcsc_pkg::OFS_FLAGS, 32'h7);
  endtask
  task automatic t_irq();
    logic [31:0] q;
    wr(adcsc_pkg::OFS_IRQ_SET, 32'h1);
    conv(1'b0, q);
    `CHK(irq_o, 1'b1)
    wr(adcsc_pkg::OFS_IRQ_CLR, 32'h7);
    `CHK(irq_o, 1'b0)
    wr(adcsc_pkg::OFS_IRQ_SET, 32'h1);
    `CHK(irq_o, 1'b1)
    wr(adcsc_pkg::OFS_FLAGS, 32'h0);
    `CHK(irq_o, 1'b1)
    wr(adcsc_pkg::OFS_FLAGS, 32'h1);
    `CHK(irq_o, 1'b0)
    wr(adcsc_pkg::OFS_IRQ_CLR, 32'h7);
  endtask
  task automatic t_overrun();
    logic [31:0] q;
    int          t;
    wr(adcsc_pkg::OFS_START, 32'h1);
    wait_dma(t);
    wr(adcsc_pkg::OFS_START, 32'h1);
    poll(32'h2, q);
    `CHK(q[1], 1'b1)
    bus(1'b1, adcsc_pkg::OFS_RESULT, 32'h0, q);
    wr(adcsc_pkg::OFS_FLAGS, 32'h7);
  endtask
  task automatic t_window();
    logic [31:0] q;
    wr(adcsc_pkg::OFS_CTRL, 32'h11);
    wr(adcsc_pkg::OFS_WINDOW_CONTROL_REGISTER, 32'h0001_0200);
    code <= 12'h300;
    conv(1'b0, q);
    bus(1'b1, adcsc_pkg::OFS_FLAGS, 32'h0, q);
    `CHK(q[2], 1'b0)
    code <= 12'h100;
    conv(1'b0, q);
    poll(32'h4, q);
    `CHK(q[2], 1'b1)
    wr(adcsc_pkg::OFS_FLAGS, 32'h7);
  endtask
  task automatic t_avg();
    logic [31:0] q;
    int          r0;
    wr(adcsc_pkg::OFS_CTRL, 32'h9);
    wr(adcsc_pkg::OFS_SAMPLEN, 32'h0);
    code <= 12'h123;
    r0 = rises;
    conv(1'b0, q);
    `CHK(rises - r0, adcsc_pkg::AVG_SAMPLES)
    `CHK(q[11:0], 12'h123)
    wr(adcsc_pkg::OFS_FLAGS, 32'h7);
  endtask
  task automatic t_free();
    logic [31:0] q[3];
    int          t[4];
    wr(adcsc_pkg::OFS_SAMPLEN, 32'h3);
    wr(adcsc_pkg::OFS_GAIN, 32'h800);
    wr(adcsc_pkg::OFS_OFFSET, 32'h0);
    code <= 12'h321;
    wr(adcsc_pkg::OFS_CTRL, 32'h7);
    t[0] = cyc;
    wr(adcsc_pkg::OFS_START, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wait_dma(t[i + 1]);
      bus(1'b1, adcsc_pkg::OFS_RESULT, 32'h0, q[i]);
      `CHK(q[i][11:0], 12'h321)
    end
    `CHK((t[1] - t[0]) > (t[3] - t[2]) + 10, 1'b1)
    wr(adcsc_pkg::OFS_CTRL, 32'h0);
  endtask
  // ==========================================================================
  // Run control
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_raw();
    t_corr();
    t_irq();
    t_overrun();
    t_window();
    t_avg();
    t_free();
    stop_test();
  end
endmodule
